// ### src/tpw_defs.svh
`ifndef TPW_DEFS_SVH
`define TPW_DEFS_SVH
// Summary of operation
// - Pulse mode toggles main pin on underflow
// - Division is (prescaler+1) times (timer+1)
// - Counters decrement and reload on underflow
// - Counting begins after start bit written one
// - Start zero or stop one halts counting
// - Every timer underflow raises the interrupt
// - Writes load reload and counter; reads count
// - Polarity zero starts output high, one low
// - Mode register write restores starting level
// - Output control one disables main pin output
// - Secondary enable drives inverted main output in pulse and event modes
// - Event mode counts selected main pin edges
// - Event mode toggles secondary pin on underflow
// - Filter field picks none, f1, f8, f32
// - Filter accepts level after three equal samples
// - Gate field: always, line two, other timer
// - Line two gate level follows edge polarity
// - Width mode counts only at measured level
// - Polarity bit chooses measured input level
// - Width mode interrupts at measured period end
// - Running writes reach counters on next tick
// - Flags clear on zero write, keep on one
// - Mode codes 001, 010, 011 select modes

// Register offsets on the 16-bit register port
`define TPW_OFS_CTRL    16'h0100
`define TPW_OFS_IOC     16'h0101
`define TPW_OFS_MODE    16'h0102
`define TPW_OFS_PRE     16'h0103
`define TPW_OFS_TMR     16'h0104
`define TPW_OFS_PSEL    16'h0105
// Control register bits
`define TPW_CTRL_START  0
`define TPW_CTRL_STAT   1
`define TPW_CTRL_STOP   2
`define TPW_CTRL_EDGF   4
`define TPW_CTRL_UNDF   5
// I/O control register bits
`define TPW_IOC_POL     0
`define TPW_IOC_ODIS    1
`define TPW_IOC_SECEN   2
`define TPW_IOC_FILT_LO 4
`define TPW_IOC_FILT_HI 5
`define TPW_IOC_GATE_LO 6
`define TPW_IOC_GATE_HI 7
// Mode register fields
`define TPW_MODE_LO     0
`define TPW_MODE_HI     2
`define TPW_CS_LO       4
`define TPW_CS_HI       5
`define TPW_CUT         7
`define TPW_PSEL_MASK   8'h1B
// Reset values
`define TPW_REG_RST     8'h00
`define TPW_CNT_RST     8'hFF
`define TPW_CNT_ZERO    8'h00
`define TPW_LVL_RST     1'b1
// Codes of two-bit fields
`define TPW_CS_F1       2'h0
`define TPW_CS_F8       2'h1
`define TPW_CS_OCO      2'h2
`define TPW_CS_F2       2'h3
`define TPW_FILT_NONE   2'h0
`define TPW_FILT_F1     2'h1
`define TPW_FILT_F8     2'h2
`define TPW_FILT_F32    2'h3
`define TPW_GATE_ALW    2'h0
`define TPW_GATE_INT    2'h1
`define TPW_GATE_OTH    2'h2
`define TPW_GATE_BAD    2'h3
// Divider taps for sampling strobes
`define TPW_DIV_W       5
`define TPW_DIV_F8      5'h07
`define TPW_DIV_F32     5'h1F
`endif

// ### src/tpw_pkg.sv
package tpw_pkg;
    // Operating modes of the timer
    typedef enum logic [2:0] {
        TPW_TIMER  = 3'h0,
        TPW_PULSE  = 3'h1,
        TPW_EVENT  = 3'h2,
        TPW_PWIDTH = 3'h3,
        TPW_PPER   = 3'h4
    } tpw_mode_type;
endpackage

// ### src/tpw_link_if.sv
`timescale 1ns/100ps
// Count source and input filter links between the timer's parts
interface tpw_link_if;
    logic [1:0] cs_sel;
    logic       cut;
    logic       tick;
    logic       f8_stb;
    logic       f32_stb;
    logic [1:0] filt_sel;
    logic       filt_lvl;
    modport div  (input cs_sel, cut, output tick, f8_stb, f32_stb);
    modport filt (input filt_sel, f8_stb, f32_stb, output filt_lvl);
    modport core (output cs_sel, cut, filt_sel, input tick, filt_lvl);
endinterface

// ### src/tpw_src_div.sv
`timescale 1ns/100ps
`include "tpw_defs.svh"
module tpw_src_div (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Slow oscillator from another clock
    input  wire logic oco_clk_in,
    // Link to the timer core and filter
    tpw_link_if.div   lnk
);
    logic [`TPW_DIV_W-1:0] div_reg;
    logic oco_s1_reg, oco_s2_reg, oco_s3_reg;
    logic tick_reg, f8_reg, f32_reg, tick_next;

    // Free divider; strobes are one clock wide
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            div_reg <= '0;
            f8_reg  <= 1'b0;
            f32_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + `TPW_DIV_W'(1);
            f8_reg  <= (div_reg[2:0] == 3'(`TPW_DIV_F8));
            f32_reg <= (div_reg == `TPW_DIV_F32);
        end
    end

    // Oscillator must be slower than half clk_in to be seen
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            oco_s1_reg <= 1'b0;
            oco_s2_reg <= 1'b0;
            oco_s3_reg <= 1'b0;
        end else begin
            oco_s1_reg <= oco_clk_in;
            oco_s2_reg <= oco_s1_reg;
            oco_s3_reg <= oco_s2_reg;
        end
    end

    // Count source choice, cut off by the cutoff bit
    always_comb begin
        unique case (lnk.cs_sel)
            `TPW_CS_F1:  tick_next = 1'b1;
            `TPW_CS_F8:  tick_next = (div_reg[2:0] == 3'(`TPW_DIV_F8));
            `TPW_CS_OCO: tick_next = oco_s2_reg & ~oco_s3_reg;
            `TPW_CS_F2:  tick_next = div_reg[0];
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) tick_reg <= 1'b0;
        else tick_reg <= tick_next & ~lnk.cut;
    end

    assign lnk.tick    = tick_reg;
    assign lnk.f8_stb  = f8_reg;
    assign lnk.f32_stb = f32_reg;
endmodule

// ### src/tpw_in_filter.sv
`timescale 1ns/100ps
`include "tpw_defs.svh"
module tpw_in_filter (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Raw main pin level
    input  wire logic pin_in,
    // Link to the timer core and divider
    tpw_link_if.filt  lnk
);
    logic       s1_reg, s2_reg, lvl_reg, stb;
    logic [2:0] smp_reg;

    function automatic logic all_same(input logic [2:0] v);
        all_same = (v == 3'h0) || (v == 3'h7);
    endfunction

    // Two flops before anything reads the pin
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
        end
    end

    // Sampling strobe per filter selection
    always_comb begin
        unique case (lnk.filt_sel)
            `TPW_FILT_NONE: stb = 1'b1;
            `TPW_FILT_F1:   stb = 1'b1;
            `TPW_FILT_F8:   stb = lnk.f8_stb;
            `TPW_FILT_F32:  stb = lnk.f32_stb;
        endcase
    end

    // Level accepted after three equal samples and glitches dropped; with no filter the level passes at once
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            smp_reg <= 3'h0;
            lvl_reg <= 1'b0;
        end else if (lnk.filt_sel == `TPW_FILT_NONE) begin
            smp_reg <= {3{s2_reg}};
            lvl_reg <= s2_reg;
        end else if (stb) begin
            smp_reg <= {smp_reg[1:0], s2_reg};
            if (all_same({smp_reg[1:0], s2_reg})) begin
                lvl_reg <= s2_reg;
            end
        end
    end

    assign lnk.filt_lvl = lvl_reg;
endmodule

// ### src/tpw_timer.sv
`timescale 1ns/100ps
`include "tpw_defs.svh"
module tpw_timer (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Register port
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    // Main timer pin, two-way
    input  wire logic        main_timer_pin_in,
    output logic             main_timer_pin_out,
    output logic             main_timer_pin_oe_out,
    // Secondary timer pin
    output logic             secondary_timer_out_pin_out,
    output logic             secondary_timer_out_pin_oe_out,
    // System inputs
    input  wire logic        on_chip_oscillator_clock_in,
    input  wire logic        external_interrupt_line_two_in,
    input  wire logic        interrupt_edge_polarity_in,
    input  wire logic        other_timer_output_d_in,
    // Interrupt request
    output logic             timer_irq_out
);
    // =========================================================
    // Declarations
    // =========================================================
    tpw_link_if lnk ();
    tpw_pkg::tpw_mode_type mode;
    logic [7:0] ioc_reg, mode_reg, psel_reg, rdata_next;
    logic [7:0] pre_rld_reg, pre_cnt_reg, tm_rld_reg, tm_cnt_reg;
    logic       start_reg, stat_reg, undf_reg, edgf_reg, lvl_reg;
    logic       pre_pend_reg, tm_pend_reg, irq_reg, filt_d_reg;
    logic       external_interrupt_line_two_s1_reg, external_interrupt_line_two_s2_reg;
    logic       run, wr_ctrl, wr_ioc, wr_mode, wr_pre, wr_tm, wr_psel;
    logic       stop_wr, interrupt_edge_polarity, gate_ok, ev_edge, src, cnt_tick;
    logic       pre_uf, tm_uf, pw_end, toggles;

    function automatic logic wr_at(input logic [15:0] ofs);
        wr_at = reg_wr_in && (reg_addr_in == ofs);
    endfunction

    // =========================================================
    // Submodules
    // =========================================================
    tpw_src_div u_div (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .oco_clk_in (on_chip_oscillator_clock_in),
        .lnk        (lnk.div)
    );

    tpw_in_filter u_filt (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .pin_in   (main_timer_pin_in),
        .lnk      (lnk.filt)
    );

    assign lnk.cs_sel   = mode_reg[`TPW_CS_HI:`TPW_CS_LO];
    assign lnk.cut      = mode_reg[`TPW_CUT];
    assign lnk.filt_sel = ioc_reg[`TPW_IOC_FILT_HI:`TPW_IOC_FILT_LO];

    // =========================================================
    // Register writes
    // =========================================================
    assign wr_ctrl = wr_at(`TPW_OFS_CTRL);
    assign wr_ioc  = wr_at(`TPW_OFS_IOC);
    assign wr_mode = wr_at(`TPW_OFS_MODE);
    assign wr_pre  = wr_at(`TPW_OFS_PRE);
    assign wr_tm   = wr_at(`TPW_OFS_TMR);
    assign wr_psel = wr_at(`TPW_OFS_PSEL);
    assign stop_wr = wr_ctrl & reg_wdata_in[`TPW_CTRL_STOP];
    assign mode    = tpw_pkg::tpw_mode_type'(
                         mode_reg[`TPW_MODE_HI:`TPW_MODE_LO]);
    assign interrupt_edge_polarity     = ioc_reg[`TPW_IOC_POL];

    // Configuration registers; bus assist bit is only stored
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ioc_reg  <= `TPW_REG_RST;
            mode_reg <= `TPW_REG_RST;
            psel_reg <= `TPW_REG_RST;
        end else begin
            if (wr_ioc) ioc_reg <= reg_wdata_in;
            if (wr_mode) mode_reg <= reg_wdata_in;
            if (wr_psel) psel_reg <= reg_wdata_in & `TPW_PSEL_MASK;
        end
    end

    // Start and status; status lags start by one clock
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            start_reg <= 1'b0;
            stat_reg  <= 1'b0;
        end else if (stop_wr) begin
            start_reg <= 1'b0;
            stat_reg  <= 1'b0;
        end else begin
            if (wr_ctrl) start_reg <= reg_wdata_in[`TPW_CTRL_START];
            stat_reg <= start_reg;
        end
    end

    // Both must be set, so a zero write stops at once
    assign run = start_reg & stat_reg;

    // =========================================================
    // Event input path
    // =========================================================
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            external_interrupt_line_two_s1_reg <= 1'b0;
            external_interrupt_line_two_s2_reg <= 1'b0;
            filt_d_reg  <= 1'b0;
        end else begin
            external_interrupt_line_two_s1_reg <= external_interrupt_line_two_in;
            external_interrupt_line_two_s2_reg <= external_interrupt_line_two_s1_reg;
            filt_d_reg  <= lnk.filt_lvl;
        end
    end

    // Gate: prohibited code blocks events rather than guessing
    always_comb begin
        unique case (ioc_reg[`TPW_IOC_GATE_HI:`TPW_IOC_GATE_LO])
            `TPW_GATE_ALW: gate_ok = 1'b1;
            `TPW_GATE_INT: gate_ok = interrupt_edge_polarity_in ?
                                     ~external_interrupt_line_two_s2_reg : external_interrupt_line_two_s2_reg;
            `TPW_GATE_OTH: gate_ok = ~other_timer_output_d_in;
            `TPW_GATE_BAD: gate_ok = 1'b0;
        endcase
    end

    // Active edge of the filtered level, one clock late
    assign ev_edge = gate_ok & (interrupt_edge_polarity ? (filt_d_reg & ~lnk.filt_lvl)
                                    : (~filt_d_reg & lnk.filt_lvl));

    // End of measured period: input leaves the measured level
    assign pw_end = run && (mode == tpw_pkg::TPW_PWIDTH) &&
                    (filt_d_reg == interrupt_edge_polarity) && (lnk.filt_lvl != interrupt_edge_polarity);

    // =========================================================
    // Count source per mode
    // =========================================================
    always_comb begin
        unique case (mode)
            tpw_pkg::TPW_TIMER:  src = lnk.tick;
            tpw_pkg::TPW_PULSE:  src = lnk.tick;
            tpw_pkg::TPW_EVENT:  src = ev_edge;
            tpw_pkg::TPW_PWIDTH: src = lnk.tick &
                                       (lnk.filt_lvl == interrupt_edge_polarity);
            tpw_pkg::TPW_PPER:   src = lnk.tick;
            default:             src = 1'b0;
        endcase
    end

    assign cnt_tick = run & src;
    assign pre_uf = cnt_tick & ~pre_pend_reg & (pre_cnt_reg == `TPW_CNT_ZERO);
    assign tm_uf  = pre_uf & ~tm_pend_reg & (tm_cnt_reg == `TPW_CNT_ZERO);

    // =========================================================
    // Prescaler
    // =========================================================
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || stop_wr) begin
            pre_rld_reg  <= `TPW_CNT_RST;
            pre_cnt_reg  <= `TPW_CNT_RST;
            pre_pend_reg <= 1'b0;
        end else if (wr_pre) begin
            pre_rld_reg  <= reg_wdata_in;
            if (!run) pre_cnt_reg <= reg_wdata_in;
            pre_pend_reg <= run;
        end else if (cnt_tick) begin
            pre_pend_reg <= 1'b0;
            if (pre_pend_reg || pre_cnt_reg == `TPW_CNT_ZERO)
                pre_cnt_reg <= pre_rld_reg;
            else
                pre_cnt_reg <= pre_cnt_reg - 8'h01;
        end
    end

    // =========================================================
    // Timer counter, clocked by prescaler underflow
    // =========================================================
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || stop_wr) begin
            tm_rld_reg  <= `TPW_CNT_RST;
            tm_cnt_reg  <= `TPW_CNT_RST;
            tm_pend_reg <= 1'b0;
        end else if (wr_tm) begin
            tm_rld_reg  <= reg_wdata_in;
            if (!run) tm_cnt_reg <= reg_wdata_in;
            tm_pend_reg <= run;
        end else if (pre_uf) begin
            tm_pend_reg <= 1'b0;
            if (tm_pend_reg || tm_cnt_reg == `TPW_CNT_ZERO)
                tm_cnt_reg <= tm_rld_reg;
            else
                tm_cnt_reg <= tm_cnt_reg - 8'h01;
        end
    end

    // =========================================================
    // Flags and interrupt
    // =========================================================
    // Hardware set beats a software clear in the same clock
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            undf_reg <= 1'b0;
            edgf_reg <= 1'b0;
        end else begin
            if (tm_uf) undf_reg <= 1'b1;
            else if (wr_ctrl && !reg_wdata_in[`TPW_CTRL_UNDF])
                undf_reg <= 1'b0;
            if (pw_end) edgf_reg <= 1'b1;
            else if (wr_ctrl && !reg_wdata_in[`TPW_CTRL_EDGF])
                edgf_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) irq_reg <= 1'b0;
        else irq_reg <= tm_uf | pw_end;
    end

    assign timer_irq_out = irq_reg;

    // =========================================================
    // Pulse level and pins
    // =========================================================
    assign toggles = (mode == tpw_pkg::TPW_PULSE) ||
                     (mode == tpw_pkg::TPW_EVENT);

    // Mode write restarts the pulse at its chosen first level
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) lvl_reg <= `TPW_LVL_RST;
        else if (wr_mode) lvl_reg <= ~interrupt_edge_polarity;
        else if (tm_uf && toggles) lvl_reg <= ~lvl_reg;
    end

    assign main_timer_pin_out    = lvl_reg;
    assign main_timer_pin_oe_out = (mode == tpw_pkg::TPW_PULSE) &
                                   ~ioc_reg[`TPW_IOC_ODIS];
    assign secondary_timer_out_pin_out    = ~lvl_reg;
    assign secondary_timer_out_pin_oe_out = toggles &
                                   ioc_reg[`TPW_IOC_SECEN];

    // =========================================================
    // Register reads, data valid the clock after the strobe
    // =========================================================
    always_comb begin
        rdata_next = `TPW_REG_RST;
        unique case (reg_addr_in)
            `TPW_OFS_CTRL: begin
                rdata_next[`TPW_CTRL_START] = start_reg;
                rdata_next[`TPW_CTRL_STAT]  = stat_reg;
                rdata_next[`TPW_CTRL_EDGF]  = edgf_reg;
                rdata_next[`TPW_CTRL_UNDF]  = undf_reg;
            end
            `TPW_OFS_IOC:  rdata_next = ioc_reg;
            `TPW_OFS_MODE: rdata_next = mode_reg;
            `TPW_OFS_PRE:  rdata_next = pre_cnt_reg;
            `TPW_OFS_TMR:  rdata_next = tm_cnt_reg;
            `TPW_OFS_PSEL: rdata_next = psel_reg;
            default:       rdata_next = `TPW_REG_RST;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) reg_rdata_out <= `TPW_REG_RST;
        else if (reg_rd_in) reg_rdata_out <= rdata_next;
        else reg_rdata_out <= `TPW_REG_RST;
    end

    // =========================================================
    // Assertions
    // =========================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_toggle;
        tm_uf && !wr_mode && (mode == tpw_pkg::TPW_PULSE)
            |=> main_timer_pin_out != $past(main_timer_pin_out);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("pulse level did not toggle");

    property p_reload;
        cnt_tick && !wr_pre && !stop_wr && !pre_pend_reg &&
            pre_cnt_reg == `TPW_CNT_ZERO |=> pre_cnt_reg == $past(pre_rld_reg);
    endproperty
    a_reload: assert property (p_reload)
        else $error("prescaler did not reload");

    property p_idle;
        !run && !reg_wr_in |=> $stable(pre_cnt_reg) && $stable(tm_cnt_reg);
    endproperty
    a_idle: assert property (p_idle)
        else $error("counter moved while stopped");

    property p_stop;
        stop_wr |=> !start_reg && !stat_reg && pre_cnt_reg == `TPW_CNT_RST
                    && tm_cnt_reg == `TPW_CNT_RST;
    endproperty
    a_stop: assert property (p_stop)
        else $error("forced stop did not reset");

    property p_irq;
        tm_uf |=> timer_irq_out ##1 (undf_reg || $past(wr_ctrl));
    endproperty
    a_irq: assert property (p_irq)
        else $error("underflow raised no request");

    property p_wrload;
        wr_pre && !run |=> pre_cnt_reg == $past(reg_wdata_in)
                           && pre_rld_reg == $past(reg_wdata_in);
    endproperty
    a_wrload: assert property (p_wrload)
        else $error("stopped write not loaded");

    property p_defer;
        wr_tm && run |=> tm_pend_reg && $stable(tm_cnt_reg);
    endproperty
    a_defer: assert property (p_defer)
        else $error("running timer write not deferred");

    property p_startlvl;
        wr_mode |=> main_timer_pin_out == !$past(interrupt_edge_polarity);
    endproperty
    a_startlvl: assert property (p_startlvl)
        else $error("start level not restored");

    property p_sec;
        ioc_reg[`TPW_IOC_SECEN] && mode == tpw_pkg::TPW_PULSE
            |-> secondary_timer_out_pin_oe_out &&
                secondary_timer_out_pin_out != main_timer_pin_out;
    endproperty
    a_sec: assert property (p_sec)
        else $error("secondary output not inverted");

    property p_clr;
        wr_ctrl && !reg_wdata_in[`TPW_CTRL_UNDF] && !tm_uf |=> !undf_reg;
    endproperty
    a_clr: assert property (p_clr)
        else $error("underflow flag not cleared");

    property p_pwgate;
        mode == tpw_pkg::TPW_PWIDTH && lnk.filt_lvl != interrupt_edge_polarity && !reg_wr_in
            |=> $stable(pre_cnt_reg);
    endproperty
    a_pwgate: assert property (p_pwgate)
        else $error("width count off measured level");

    c_pulse: cover property (tm_uf && mode == tpw_pkg::TPW_PULSE);
    c_event: cover property (run && ev_edge && mode == tpw_pkg::TPW_EVENT);
    c_pwend: cover property (pw_end ##1 timer_irq_out);
endmodule

// ### tb/tpw_pin_src.sv
`timescale 1ns/100ps
// ====
// Pulse source standing on the main timer pin
module tpw_pin_src (
    // Clock
    input  wire logic clk_in,
    // Level driven onto the pin
    output logic      pin_out
);
    // Rest low; changes follow an edge so the synchroniser never races
    initial begin
        pin_out = 1'b0;
    end
    // One high phase then one low phase, lengths in clocks
    task automatic pulse(input int hi, input int lo);
        @(posedge clk_in);
        pin_out <= 1'b1;
        repeat (hi) @(posedge clk_in);
        pin_out <= 1'b0;
        repeat (lo - 1) @(posedge clk_in);
    endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
// ====
// Self-checking bench for the prescaled timer
module tb;
    logic        clk_in;
    logic        rst_n_in;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr_s;
    logic        rd_s;
    logic [7:0]  rdata;
    logic        pin;
    logic        m_out;
    logic        m_oe;
    logic        s_out;
    logic        s_oe;
    logic        irq;
    logic        oth;
    int          error_cnt;
    int          cmp_count;
    int          irq_n;
    int          cyc;

    // Slow source and line two gate are idle, other timer input follows oth: only f1 counting is used
    tpw_timer tpw_timer_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
        .reg_rdata_out(rdata), .main_timer_pin_in(pin),
        .main_timer_pin_out(m_out), .main_timer_pin_oe_out(m_oe),
        .secondary_timer_out_pin_out(s_out),
        .secondary_timer_out_pin_oe_out(s_oe),
        .on_chip_oscillator_clock_in(1'b0),
        .external_interrupt_line_two_in(1'b0),
        .interrupt_edge_polarity_in(1'b0),
        .other_timer_output_d_in(oth), .timer_irq_out(irq));
    tpw_pin_src tpw_pin_src_i (.clk_in(clk_in), .pin_out(pin));

    // ====
    // Clock, interrupt tally and hang guard
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (irq === 1'b1) irq_n++;
        if (cyc == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ====
    // Register port and checking helpers
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk_in);
        wr_s <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_in);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(v === e, "read data mismatch");
    endtask
    // Bounded wait for the next interrupt pulse, n = clocks waited
    task automatic wirq(output int n);
        n = 0;
        do begin
            @(posedge clk_in);
            #1 n++;
        end while (irq !== 1'b1 && n < 200);
    endtask

    // ====
    // Scenarios
    task automatic t_reset();
        chk(m_oe === 1'b0 && s_oe === 1'b0, "pins driven after reset");
        rdc(16'h0100, 8'h00);
        rdc(16'h0101, 8'h00);
        rdc(16'h0103, 8'hFF);
        rdc(16'h01FF, 8'h00);
    endtask
    task automatic t_pulse();
        int n;
        int k;
        logic lv;
        wr(16'h0103, 8'h01);
        wr(16'h0104, 8'h01);
        wr(16'h0101, 8'h04);
        wr(16'h0102, 8'h01);
        chk(m_out === 1'b1 && m_oe === 1'b1, "pulse start level");
        rdc(16'h0100, 8'h00);
        wr(16'h0100, 8'h01);
        wirq(n);
        lv = m_out;
        wirq(n);
        chk(n == 4 && m_out === ~lv, "pulse period");
        chk(s_out === lv, "secondary not inverted");
        wr(16'h0100, 8'h00);
        wr(16'h0101, 8'h07);
        k = irq_n;
        wr(16'h0102, 8'h01);
        chk(m_out === 1'b0 && m_oe === 1'b0, "restart level");
        chk(irq_n == k, "counting after start cleared");
        wr(16'h0100, 8'h04);
        rdc(16'h0103, 8'hFF);
    endtask
    task automatic t_event();
        int k;
        wr(16'h0103, 8'h00);
        wr(16'h0104, 8'h02);
        wr(16'h0101, 8'h04);
        wr(16'h0102, 8'h02);
        chk(s_out === 1'b0 && s_oe === 1'b1, "event start level");
        wr(16'h0100, 8'h01);
        k = irq_n;
        repeat (3) tpw_pin_src_i.pulse(5, 5);
        chk(irq_n - k == 1 && s_out === 1'b1, "event count");
        wr(16'h0101, 8'h14);
        k = irq_n;
        repeat (3) tpw_pin_src_i.pulse(1, 6);
        chk(irq_n == k, "glitch counted");
        repeat (3) tpw_pin_src_i.pulse(6, 6);
        chk(irq_n - k == 1, "filtered edges lost");
        wr(16'h0101, 8'h84);
        @(posedge clk_in);
        oth <= 1'b1;
        k = irq_n;
        repeat (3) tpw_pin_src_i.pulse(5, 5);
        chk(irq_n == k, "gated edges counted");
        wr(16'h0100, 8'h04);
    endtask
    task automatic t_width();
        int k;
        logic [7:0] v;
        wr(16'h0103, 8'h00);
        wr(16'h0104, 8'hFF);
        wr(16'h0101, 8'h01);
        wr(16'h0102, 8'h03);
        wr(16'h0100, 8'h01);
        k = irq_n;
        tpw_pin_src_i.pulse(10, 8);
        rd(16'h0104, v);
        chk(v < 8'hFF && v > 8'hF0, "width count");
        rdc(16'h0100, 8'h13);
        chk(irq_n - k == 1, "period end request");
        wr(16'h0100, 8'h21);
        rdc(16'h0100, 8'h03);
        rd(16'h0104, v);
        repeat (20) @(posedge clk_in);
        rdc(16'h0104, v);
    endtask

    // ====
    // Verdict and end of run
    task automatic wrap_up();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Reset, then the scenarios in turn
    initial begin
        addr     = 16'h0000;
        wdata    = 8'h00;
        wr_s     = 1'b0;
        rd_s     = 1'b0;
        oth      = 1'b0;
        rst_n_in = 1'b0;
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        t_reset();
        t_pulse();
        t_event();
        t_width();
        wrap_up();
    end
endmodule
